/* core/scc_pkg.sv */
package scc_pkg;

  // Bus addresses, full byte including the direction bit
  localparam logic [7:0] SCC_WR_ADDR = 8'hd2;
  localparam logic [7:0] SCC_RD_ADDR = 8'hd3;

  // Register indices
  localparam logic [7:0] SCC_OFS_SPREAD = 8'h00;
  localparam logic [7:0] SCC_OFS_OUT_EN = 8'h01;
  localparam logic [7:0] SCC_OFS_GFX_REQ = 8'h02;
  localparam logic [7:0] SCC_OFS_COUNT = 8'h08;

  // Values after reset
  localparam logic [4:0] SCC_RST_SPREAD_HI = 5'h00;
  localparam logic [7:0] SCC_RST_OUT_EN = 8'hff;
  localparam logic [7:0] SCC_RST_GFX_REQ = 8'h30;
  localparam logic [7:0] SCC_RST_COUNT = 8'h09;

  // Byte 2: writable bits and the fixed reserved pattern
  localparam logic [7:0] SCC_GFX_RW_MASK = 8'h3a;
  localparam logic [7:0] SCC_GFX_RSVD_VAL = 8'hc0;

  // Field positions
  localparam int SCC_B0_ORIGIN = 7;
  localparam int SCC_B0_GFX_SS = 6;
  localparam int SCC_B0_SRC_SS = 5;
  localparam int SCC_B0_CPU_SS = 4;
  localparam int SCC_B2_GFX1 = 5;
  localparam int SCC_B2_GFX0 = 4;
  localparam int SCC_B2_REQ4 = 3;
  localparam int SCC_B2_REQ2 = 1;

  // Bit counter values within one byte slot
  localparam logic [3:0] SCC_LAST_BIT = 4'h7;
  localparam logic [3:0] SCC_ACK_SLOT = 4'h8;

  typedef enum logic [2:0] {
    SCC_ST_IDLE = 3'b000,
    SCC_ST_ADDR = 3'b001,
    SCC_ST_INDEX = 3'b010,
    SCC_ST_COUNT = 3'b011,
    SCC_ST_WDATA = 3'b100,
    SCC_ST_RDATA = 3'b101,
    SCC_ST_IGNORE = 3'b110
  } scc_state_type;

  // Events from the bit engine, one-cycle pulses except the byte and host_nack
  typedef struct packed {
    logic start;
    logic stop;
    logic rx_valid;
    logic host_ack;
    logic host_nack;
    logic [7:0] rx_byte;
  } scc_bit_evt_type;

  // Control levels to the clock generator
  typedef struct packed {
    logic freq_select_origin;
    logic graphics_spread_enable;
    logic serial_ref_spread_enable;
    logic processor_spread_enable;
    logic [3:0] processor_freq_sel;
    logic usb_clock_out_1;
    logic usb_clock_out_0;
    logic crystal_ref_out_2;
    logic crystal_ref_out_1;
    logic crystal_ref_out_0;
    logic link_seed_clock;
    logic processor_pair_1;
    logic processor_pair_0;
    logic graphics_pair_1;
    logic graphics_pair_0;
    logic serial_pair_4_run;
    logic serial_pair_2_run;
  } scc_clk_ctrl_type;

endpackage

/* core/scc_smb_bits.sv */
`timescale 1ns/100ps
`default_nettype none
module scc_smb_bits
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic smb_clk,
  input wire logic smb_data_in,
  input wire logic tx_mode,
  input wire logic [7:0] tx_byte,
  input wire logic ack_en,
  output scc_bit_evt_type evt,
  output logic data_oe
);

  logic scl_meta_ff;
  logic scl_sync_ff;
  logic scl_prev_ff;
  logic sda_meta_ff;
  logic sda_sync_ff;
  logic sda_prev_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_sh_ff;
  logic byte_tx_ff;
  logic drive_ff;
  scc_bit_evt_type evt_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Both pins come from the host's domain; no reset needed on the chain
  always_ff @(posedge clk) begin
    scl_meta_ff <= smb_clk;
    scl_sync_ff <= scl_meta_ff;
    scl_prev_ff <= scl_sync_ff;
    sda_meta_ff <= smb_data_in;
    sda_sync_ff <= sda_meta_ff;
    sda_prev_ff <= sda_sync_ff;
  end

  // Edges and bus conditions, from the second stage onward only
  assign scl_rise = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff & scl_prev_ff;
  assign start_seen = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign stop_seen = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  // Bit slots: sample on rising edges, change the line on falling ones
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      byte_tx_ff <= 1'h0;
      drive_ff <= 1'h0;
      evt_ff <= '0;
    end else begin
      evt_ff.start <= start_seen;
      evt_ff.stop <= stop_seen;
      evt_ff.rx_valid <= 1'h0;
      evt_ff.host_ack <= 1'h0;
      if (start_seen || stop_seen) begin
        // Any bus condition frees the line and restarts the slot
        cnt_ff <= 4'h0;
        byte_tx_ff <= 1'h0;
        drive_ff <= 1'h0;
      end else if (scl_rise) begin
        if (cnt_ff == SCC_ACK_SLOT) begin
          cnt_ff <= 4'h0;
          evt_ff.host_ack <= byte_tx_ff; // see RL6
          evt_ff.host_nack <= sda_sync_ff; // see RL7
        end else begin
          shift_ff <= {shift_ff[6:0], sda_sync_ff};
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == SCC_LAST_BIT) begin
            evt_ff.rx_valid <= ~byte_tx_ff;
            evt_ff.rx_byte <= {shift_ff[6:0], sda_sync_ff};
          end
        end
      end else if (scl_fall) begin
        if (cnt_ff == SCC_ACK_SLOT) begin
          // Pull low to acknowledge a received byte; let go when sending
          drive_ff <= ack_en & ~byte_tx_ff;
        end else if (cnt_ff == 4'h0) begin
          byte_tx_ff <= tx_mode;
          tx_sh_ff <= {tx_byte[6:0], 1'h0};
          drive_ff <= tx_mode & ~tx_byte[7];
        end else begin
          drive_ff <= byte_tx_ff & ~tx_sh_ff[7];
          tx_sh_ff <= {tx_sh_ff[6:0], 1'h0};
        end
      end
    end
  end

  assign evt = evt_ff;
  assign data_oe = drive_ff;

endmodule
`default_nettype wire

/* core/scc_smbus_clock_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// RL1: Host writes address d2 after start; device acknowledges it.
// RL2: Next byte is the start index; acknowledged and used as first register.
// RL3: After repeated start, read address d3 is acknowledged.
// RL4: A read sends the byte count first, then register contents.
// RL5: Bytes returned in a read follow the byte-count register.
// RL6: Host acknowledges each returned byte except the last.
// RL7: Host ends a read with not-acknowledge then stop.
// RL8: Block write: address, index, count, data bytes, stop; all acknowledged.
// RL9: Byte 0 bit 7 picks strap or register frequency select; resets 0.
// RL10: Byte 0 bits 6..4 enable spread per domain; reset disabled.
// RL11: Software sets all three spread bits for spread on all domains.
// RL12: Byte 0 bits 3..0 are frequency select; low three reset from straps.
// RL13: Byte 1 holds eight output enables, all reset to one.
// RL14: Byte 2 bits 5 and 4 enable graphics pairs; reset one.
// RL15: Byte 2 bits 3 and 1 map pairs 4 and 2 to request B.
// RL16: Byte-count register is eight bits read-write, default nine.
// RL17: A mapped pair runs while request B is low, stops while high.
module scc_smbus_clock_config_regs
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic smb_clk,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  input wire logic [2:0] fs_strap,
  input wire logic clock_request_b_n,
  output scc_clk_ctrl_type clk_ctrl
);

  scc_bit_evt_type evt;
  scc_state_type state_ff;
  logic [7:0] ptr_ff;
  logic [7:0] left_ff;
  logic ack_en_ff;
  logic tx_mode_ff;
  logic [7:0] tx_byte_ff;
  logic [2:0] strap_meta_ff;
  logic [2:0] strap_sync_ff;
  logic [2:0] strap_latch_ff;
  logic req_meta_ff;
  logic req_sync_ff;
  logic [7:0] byte0_ff;
  logic [7:0] byte1_ff;
  logic [7:0] byte2_ff;
  logic [7:0] count_ff;
  scc_clk_ctrl_type ctrl_ff;
  logic wr_en;

  // Register contents as seen by a read
  function automatic logic [7:0] rd_reg(input logic [7:0] idx);
    case (idx)
      SCC_OFS_SPREAD: rd_reg = byte0_ff;
      SCC_OFS_OUT_EN: rd_reg = byte1_ff;
      SCC_OFS_GFX_REQ: rd_reg = (byte2_ff & SCC_GFX_RW_MASK)
                                | SCC_GFX_RSVD_VAL;
      SCC_OFS_COUNT: rd_reg = count_ff;
      default: rd_reg = 8'h00;
    endcase
  endfunction

  scc_smb_bits u_bits (
    .clk(clk),
    .reset(reset),
    .smb_clk(smb_clk),
    .smb_data_in(smb_data_in),
    .tx_mode(tx_mode_ff),
    .tx_byte(tx_byte_ff),
    .ack_en(ack_en_ff),
    .evt(evt),
    .data_oe(smb_data_oe)
  );

  // Open drain: only ever pulls low
  assign smb_data_out = 1'h0;

  // Straps and the request pin are asynchronous pins
  always_ff @(posedge clk) begin
    strap_meta_ff <= fs_strap;
    strap_sync_ff <= strap_meta_ff;
    req_meta_ff <= clock_request_b_n;
    req_sync_ff <= req_meta_ff;
  end

  // Straps are caught while reset is held, then frozen
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_latch_ff <= strap_sync_ff; // see RL9
    end
  end

  // Data bytes of a block write land only while the count lasts
  assign wr_en = evt.rx_valid && (state_ff == SCC_ST_WDATA)
                 && (left_ff != 8'h00); // see RL8

  // Transfer sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= SCC_ST_IDLE;
      ptr_ff <= 8'h00;
      left_ff <= 8'h00;
      ack_en_ff <= 1'h0;
      tx_mode_ff <= 1'h0;
      tx_byte_ff <= 8'hff;
    end else if (evt.stop) begin
      state_ff <= SCC_ST_IDLE;
      tx_mode_ff <= 1'h0;
      ack_en_ff <= 1'h0;
    end else if (evt.start) begin
      // Repeated start lands here too; the index is kept
      state_ff <= SCC_ST_ADDR; // see RL3
      tx_mode_ff <= 1'h0;
      ack_en_ff <= 1'h0;
    end else if (evt.rx_valid) begin
      case (state_ff)
        SCC_ST_ADDR: begin
          if (evt.rx_byte == SCC_WR_ADDR) begin
            ack_en_ff <= 1'h1; // see RL1
            state_ff <= SCC_ST_INDEX;
          end else if (evt.rx_byte == SCC_RD_ADDR) begin
            ack_en_ff <= 1'h1; // see RL3
            tx_mode_ff <= 1'h1;
            tx_byte_ff <= count_ff; // see RL4
            left_ff <= count_ff; // see RL5
            state_ff <= SCC_ST_RDATA;
          end else begin
            // Someone else's address: stay off the line
            ack_en_ff <= 1'h0;
            state_ff <= SCC_ST_IGNORE;
          end
        end
        SCC_ST_INDEX: begin
          ptr_ff <= evt.rx_byte; // see RL2
          ack_en_ff <= 1'h1;
          state_ff <= SCC_ST_COUNT;
        end
        SCC_ST_COUNT: begin
          left_ff <= evt.rx_byte; // see RL8
          ack_en_ff <= 1'h1;
          state_ff <= SCC_ST_WDATA;
        end
        SCC_ST_WDATA: begin
          // Surplus bytes are still acknowledged but not stored
          ack_en_ff <= 1'h1; // see RL8
          if (wr_en) begin
            ptr_ff <= ptr_ff + 8'h01;
            left_ff <= left_ff - 8'h01;
          end
        end
        default: begin
          ack_en_ff <= 1'h0;
        end
      endcase
    end else if (evt.host_ack && (state_ff == SCC_ST_RDATA)) begin
      if (evt.host_nack) begin
        tx_mode_ff <= 1'h0; // see RL7
        state_ff <= SCC_ST_IGNORE;
      end else if (left_ff != 8'h00) begin
        tx_byte_ff <= rd_reg(ptr_ff); // see RL6
        ptr_ff <= ptr_ff + 8'h01;
        left_ff <= left_ff - 8'h01; // see RL5
      end else begin
        // Count exhausted: release the line rather than invent data
        tx_mode_ff <= 1'h0;
      end
    end
  end

  // Byte 0, spread and frequency select
  always_ff @(posedge clk) begin
    if (reset) begin
      byte0_ff <= {SCC_RST_SPREAD_HI, strap_sync_ff}; // see RL12
    end else if (wr_en && (ptr_ff == SCC_OFS_SPREAD)) begin
      byte0_ff <= evt.rx_byte; // see RL10
    end
  end

  // Byte 1, output enables
  always_ff @(posedge clk) begin
    if (reset) begin
      byte1_ff <= SCC_RST_OUT_EN; // see RL13
    end else if (wr_en && (ptr_ff == SCC_OFS_OUT_EN)) begin
      byte1_ff <= evt.rx_byte;
    end
  end

  // Byte 2, reserved bits never stored
  always_ff @(posedge clk) begin
    if (reset) begin
      byte2_ff <= SCC_RST_GFX_REQ; // see RL14
    end else if (wr_en && (ptr_ff == SCC_OFS_GFX_REQ)) begin
      byte2_ff <= evt.rx_byte & SCC_GFX_RW_MASK; // see RL15
    end
  end

  // Byte 8, read length
  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= SCC_RST_COUNT; // see RL16
    end else if (wr_en && (ptr_ff == SCC_OFS_COUNT)) begin
      count_ff <= evt.rx_byte;
    end
  end

  // Registered control levels; one cycle behind the registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff.freq_select_origin <= byte0_ff[SCC_B0_ORIGIN];
      ctrl_ff.graphics_spread_enable <= byte0_ff[SCC_B0_GFX_SS]; // see RL10
      ctrl_ff.serial_ref_spread_enable <= byte0_ff[SCC_B0_SRC_SS];
      ctrl_ff.processor_spread_enable <= byte0_ff[SCC_B0_CPU_SS];
      // Strap path has no fourth bit, so it reads as zero
      ctrl_ff.processor_freq_sel <= byte0_ff[SCC_B0_ORIGIN]
                                    ? byte0_ff[3:0]
                                    : {1'h0, strap_latch_ff}; // see RL9
      ctrl_ff.usb_clock_out_1 <= byte1_ff[7]; // see RL13
      ctrl_ff.usb_clock_out_0 <= byte1_ff[6];
      ctrl_ff.crystal_ref_out_2 <= byte1_ff[5];
      ctrl_ff.crystal_ref_out_1 <= byte1_ff[4];
      ctrl_ff.crystal_ref_out_0 <= byte1_ff[3];
      ctrl_ff.link_seed_clock <= byte1_ff[2];
      ctrl_ff.processor_pair_1 <= byte1_ff[1];
      ctrl_ff.processor_pair_0 <= byte1_ff[0];
      ctrl_ff.graphics_pair_1 <= byte2_ff[SCC_B2_GFX1]; // see RL14
      ctrl_ff.graphics_pair_0 <= byte2_ff[SCC_B2_GFX0];
      ctrl_ff.serial_pair_4_run <= ~byte2_ff[SCC_B2_REQ4]
                                   | ~req_sync_ff; // see RL17
      ctrl_ff.serial_pair_2_run <= ~byte2_ff[SCC_B2_REQ2]
                                   | ~req_sync_ff; // see RL15
    end
  end

  assign clk_ctrl = ctrl_ff;

endmodule
`default_nettype wire

/* verif/scc_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module scc_regs_assertions
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic smb_clk,
  input wire logic smb_data_in,
  input wire logic smb_data_out,
  input wire logic smb_data_oe,
  input wire logic [2:0] fs_strap,
  input wire logic clock_request_b_n,
  input wire scc_clk_ctrl_type clk_ctrl
);
  logic [2:0] strap_ff;
  logic [7:0] hi_ff;
  logic [7:0] oe_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Straps as the device should latch them
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_ff <= fs_strap;
    end
  end
  // Clock high longer than one bit phase means the bus is idle
  always_ff @(posedge clk) begin
    if (reset || !smb_clk) begin
      hi_ff <= 8'h00;
    end else if (hi_ff != 8'hff) begin
      hi_ff <= hi_ff + 8'h01;
    end
  end
  // Length of the current pull on the data line
  always_ff @(posedge clk) begin
    if (reset || !smb_data_oe) begin
      oe_ff <= 8'h00;
    end else if (oe_ff != 8'hff) begin
      oe_ff <= oe_ff + 8'h01;
    end
  end
  a_oe_rise_low: assert property (
    $rose(smb_data_oe) |-> !smb_clk && !$past(smb_clk, 2))
    else $error("data pulled while clock high");
  a_idle_released: assert property (
    hi_ff >= 8'h0c |-> !smb_data_oe)
    else $error("data held on idle bus");
  a_pull_bounded: assert property (
    oe_ff <= 8'h96)
    else $error("data pulled past nine slots");
  a_ctrl_idle_steady: assert property (
    hi_ff >= 8'h0c |-> $stable(clk_ctrl[19:2]))
    else $error("controls moved on idle bus");
  a_strap_path: assert property (
    !$past(reset) && !clk_ctrl.freq_select_origin
    |-> clk_ctrl.processor_freq_sel == {1'h0, strap_ff})
    else $error("strap frequency path wrong");
  a_request_runs: assert property (
    (!clock_request_b_n) [*8] |-> clk_ctrl[1:0] == 2'h3)
    else $error("pair stopped while requested");
  a_reset_values: assert property (
    $fell(reset) |=> clk_ctrl[11:2] == 10'h3ff && clk_ctrl[19:16] == 4'h0)
    else $error("control reset values wrong");
  a_open_drain: assert property (
    smb_data_out == 1'h0)
    else $error("data driven high");
  cover property ($rose(smb_data_oe));
  cover property (clk_ctrl.freq_select_origin);
  cover property ($fell(clk_ctrl.serial_pair_4_run));
endmodule
bind scc_smbus_clock_config_regs scc_regs_assertions u_scc_regs_assertions (
  .clk(clk),
  .reset(reset),
  .smb_clk(smb_clk),
  .smb_data_in(smb_data_in),
  .smb_data_out(smb_data_out),
  .smb_data_oe(smb_data_oe),
  .fs_strap(fs_strap),
  .clock_request_b_n(clock_request_b_n),
  .clk_ctrl(clk_ctrl)
);
`default_nettype wire

/* verif/scc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module scc_host (
  input wire logic clk,
  output logic scl,
  output logic sda,
  input wire logic line
);
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves mid low phase, four clocks clear of each edge
  task automatic bit_slot(input logic b, output logic r);
    scl = 1'b0;
    wt(4);
    sda = b;
    wt(4);
    scl = 1'b1;
    wt(4);
    r = line;
    wt(4);
  endtask
  // Serves as first and repeated start
  task automatic start();
    scl = 1'b0;
    wt(4);
    sda = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda = 1'b0;
    wt(4);
  endtask
  task automatic stop();
    scl = 1'b0;
    wt(4);
    sda = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda = 1'b1;
    wt(8);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ack = !r;
  endtask
  // Line released while reading; ack low, else left high
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(!ack, r);
  endtask
endmodule
`default_nettype wire

/* verif/scc_smbus_clock_config_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module scc_smbus_clock_config_regs_tb
  import scc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_n = 1'b1;
  logic [2:0] strap = 3'h5;
  logic scl, hsda, oe, dout;
  scc_clk_ctrl_type ctrl;
  int fail_count = 0;
  int checks = 0;
  // Pull-up wins unless someone pulls low
  wire logic line = hsda & (oe ? dout : 1'b1);
  always #2 clk = ~clk;
  scc_smbus_clock_config_regs u_scc_smbus_clock_config_regs (
    .clk(clk),
    .reset(reset),
    .smb_clk(scl),
    .smb_data_in(line),
    .smb_data_out(dout),
    .smb_data_oe(oe),
    .fs_strap(strap),
    .clock_request_b_n(req_n),
    .clk_ctrl(ctrl)
  );
  scc_host u_scc_host (
    .clk(clk),
    .scl(scl),
    .sda(hsda),
    .line(line)
  );
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  // Expected controls from the three bytes, the straps and the request pin
  function automatic logic [19:0] model(input logic [7:0] b0, b1, b2);
    logic [3:0] fs;
    fs = b0[7] ? b0[3:0] : {1'h0, strap};
    return {b0[7:4], fs, b1, b2[5:4], ~b2[3] | ~req_n, ~b2[1] | ~req_n};
  endfunction
  task automatic wr(input logic [7:0] n, input logic [7:0] d[$]);
    logic a;
    u_scc_host.start();
    u_scc_host.send(SCC_WR_ADDR, a);
    chk(20'(a), 20'h1);
    u_scc_host.send(n, a);
    chk(20'(a), 20'h1);
    u_scc_host.send(8'(d.size()), a);
    chk(20'(a), 20'h1);
    foreach (d[i]) begin
      u_scc_host.send(d[i], a);
      chk(20'(a), 20'h1);
    end
    u_scc_host.stop();
  endtask
  task automatic rd(input logic [7:0] n, input logic [7:0] e[$]);
    logic a;
    logic [7:0] b;
    u_scc_host.start();
    u_scc_host.send(SCC_WR_ADDR, a);
    chk(20'(a), 20'h1);
    u_scc_host.send(n, a);
    chk(20'(a), 20'h1);
    u_scc_host.start();
    u_scc_host.send(SCC_RD_ADDR, a);
    chk(20'(a), 20'h1);
    u_scc_host.recv(1'b1, b);
    chk(20'(b), 20'(e.size()));
    foreach (e[i]) begin
      u_scc_host.recv(i != e.size() - 1, b);
      chk(20'(b), 20'(e[i]));
    end
    u_scc_host.stop();
  endtask
  // Defaults, straps in byte 0, unmapped bytes read zero
  task automatic t_reset();
    logic [7:0] b0;
    // Low three bits follow whatever straps the last reset caught
    b0 = {5'h00, strap};
    chk(ctrl, model(b0, 8'hff, 8'h30));
    rd(8'h00, {b0, 8'hff, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h09});
  endtask
  // All spreads on, register frequency, reserved bits not stored
  task automatic t_write();
    wr(8'h00, {8'hfa, 8'h5a, 8'hff});
    chk(ctrl, model(8'hfa, 8'h5a, 8'h3a));
    rd(8'h00, {8'hfa, 8'h5a, 8'hfa, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h09});
  endtask
  // Mapped pairs follow the request pin both ways
  task automatic t_req();
    req_n = 1'b0;
    repeat (10) @(negedge clk);
    chk(ctrl, model(8'hfa, 8'h5a, 8'h3a));
    req_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(ctrl, model(8'hfa, 8'h5a, 8'h3a));
  endtask
  // Short read length, then back to the strap path
  task automatic t_count();
    wr(8'h08, {8'h02});
    rd(8'h01, {8'h5a, 8'hfa});
    wr(8'h00, {8'h0a});
    chk(ctrl, model(8'h0a, 8'h5a, 8'h3a));
  endtask
  // A foreign address gets no answer
  task automatic t_badaddr();
    logic a;
    u_scc_host.start();
    u_scc_host.send(8'ha4, a);
    chk(20'(a), 20'h0);
    u_scc_host.stop();
  endtask
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Second reset mid-run must restore every default
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_write();
    t_req();
    t_count();
    t_badaddr();
    reset = 1'b1;
    strap = 3'h2; // Fresh straps, caught only by this reset
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    summarize();
  end
  // Whole run is near 9k cycles; 40k cycles means a hang
  initial begin
    #160000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
